//--- core/mams_mode_select.sv
// Manual/automatic mode selector with AHB-Lite control registers
//
// Overview of operation
// - Manual mode halts positioning and subtask programs
// - Auto-to-manual finishes move, then awaits end
// - Mode input acts only when enable bit set
// - Single-axis uses X3, two-axis X7; active=manual
// - Host request bit forces manual; clear means nothing
// - Panel manual position always forces manual mode
// - Panel auto, both bits clear: automatic
// - Enabled input, no host request: follow input
// - Priority: panel, host request, enabled input
`timescale 1ns/1ps
`default_nettype none
module mams_mode_select (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Panel and pins
    input  wire logic        panelManual,
    input  wire logic        modeInputSingleAxis,
    input  wire logic        modeInputTwoAxis,
    // Program sequencer handshake
    input  wire logic        autoStart,
    input  wire logic        moveBusy,
    input  wire logic        programEnd,
    output var  logic        manualOperation,
    output var  logic        programRun,
    output var  logic        subtaskRun,
    output var  logic        newMoveAllowed
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]          ctrl;
        logic                wrPend;
        logic                rdPend;
        logic [7:0]          addr;
        logic [31:0]         rdata;
        logic                manual;
        mams_pkg::mams_run_t run;
        logic                progRun;
        logic                subRun;
        logic                moveOk;
        logic                busReady;
        logic                busErr;
    } mams_state_t;

    mams_state_t state_q;
    mams_state_t state_d;

    logic [2:0] pinSync;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    mams_sync #(
        .WIDTH(3)
    ) u_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .asyncIn ({panelManual, modeInputTwoAxis, modeInputSingleAxis}),
        .syncOut (pinSync)
    );

    // ------------------------------------------------------------
    // Mode resolution
    // ------------------------------------------------------------
    function automatic logic resolveManual(
        input logic panel,
        input logic hostReq,
        input logic inEn,
        input logic modeIn
    );
        if (panel) begin
            resolveManual = 1'b1;
        end else if (hostReq) begin
            resolveManual = 1'b1;
        end else if (inEn) begin
            resolveManual = modeIn;
        end else begin
            resolveManual = 1'b0;
        end
    endfunction

    function automatic logic [31:0] readMux(
        input logic [7:0]  addr,
        input mams_state_t s,
        input logic [2:0]  pins
    );
        readMux = 32'h0;
        case (addr)
            mams_pkg::CTRL_OFFSET: begin
                readMux[2:0] = s.ctrl;
            end
            mams_pkg::STATUS_OFFSET: begin
                readMux[mams_pkg::STAT_MANUAL_BIT]   = s.manual;
                readMux[mams_pkg::STAT_AUTO_RUN_BIT] = s.run == mams_pkg::RUN_ACTIVE;
                readMux[mams_pkg::STAT_WAIT_END_BIT] = s.run == mams_pkg::RUN_WAIT_END;
                readMux[mams_pkg::STAT_PANEL_BIT]    = pins[2];
                readMux[mams_pkg::STAT_MODE_IN_BIT]  = pins[1:0] != 2'h0;
            end
            default: begin
                readMux = 32'h0;
            end
        endcase
    endfunction

    logic modeIn;
    logic manualNow;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        modeIn = state_q.ctrl[mams_pkg::CTRL_TWO_AXIS_BIT] ? pinSync[1] : pinSync[0];
        manualNow = resolveManual(pinSync[2],
                                  state_q.ctrl[mams_pkg::CTRL_HOST_MANUAL_OPERATION_BIT],
                                  state_q.ctrl[mams_pkg::CTRL_INPUT_EN_BIT],
                                  modeIn);
        state_d = state_q;
        if (clkEn) begin
            // Bus data phase
            if (state_q.wrPend && state_q.addr == mams_pkg::CTRL_OFFSET) begin
                state_d.ctrl = hwdata[2:0];
            end
            state_d.wrPend = 1'b0;
            state_d.rdPend = 1'b0;
            // Zero-wait OKAY response on every transfer
            state_d.busReady = 1'b1;
            state_d.busErr   = 1'b0;
            // Address phase: capture target and read snapshot
            if (hsel && hready && htrans[1]) begin
                state_d.addr   = haddr;
                state_d.wrPend = hwrite;
                state_d.rdPend = !hwrite;
                state_d.rdata  = readMux(haddr, state_q, pinSync);
            end
            // Effective mode, registered on every cycle with clkEn high
            state_d.manual = manualNow;

            // Program run control
            case (state_q.run)
                mams_pkg::RUN_IDLE: begin
                    if (!manualNow && autoStart) begin
                        state_d.run = mams_pkg::RUN_ACTIVE;
                    end
                end
                mams_pkg::RUN_ACTIVE: begin
                    if (programEnd) begin
                        state_d.run = mams_pkg::RUN_IDLE;
                    end else if (manualNow) begin
                        state_d.run = moveBusy ? mams_pkg::RUN_FINISH_MOVE : mams_pkg::RUN_WAIT_END;
                    end
                end
                mams_pkg::RUN_FINISH_MOVE: begin
                    if (programEnd) begin
                        state_d.run = mams_pkg::RUN_IDLE;
                    end else if (!moveBusy) begin
                        state_d.run = mams_pkg::RUN_WAIT_END;
                    end
                end
                mams_pkg::RUN_WAIT_END: begin
                    if (programEnd) begin
                        state_d.run = mams_pkg::RUN_IDLE;
                    end
                end
                default: begin
                    state_d.run = mams_pkg::RUN_IDLE;
                end
            endcase
            state_d.progRun = state_d.run == mams_pkg::RUN_ACTIVE ||
                              state_d.run == mams_pkg::RUN_FINISH_MOVE;
            state_d.subRun  = !manualNow && state_d.run == mams_pkg::RUN_ACTIVE;
            state_d.moveOk  = !manualNow && state_d.run == mams_pkg::RUN_ACTIVE;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= '{ctrl:     mams_pkg::CTRL_RESET,
                         addr:     8'h00,
                         rdata:    32'h0,
                         run:      mams_pkg::RUN_IDLE,
                         manual:   1'b1,
                         busReady: 1'b1,
                         default:  1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata          = state_q.rdata;
    assign hreadyout       = state_q.busReady;
    assign hresp           = state_q.busErr;
    assign manualOperation = state_q.manual;
    assign programRun      = state_q.progRun;
    assign subtaskRun      = state_q.subRun;
    assign newMoveAllowed  = state_q.moveOk;

endmodule // mams_mode_select
`default_nettype wire

//--- core/mams_pkg.sv
// Package of constants for the manual/automatic mode selector
package mams_pkg;

    // ------------------------------------------------------------
    // Register map (word offsets are byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_INPUT_EN_BIT   = 0;
    localparam int CTRL_HOST_MANUAL_OPERATION_BIT  = 1;
    localparam int CTRL_TWO_AXIS_BIT   = 2;
    localparam logic [2:0] CTRL_RESET  = 3'h0;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int STAT_MANUAL_BIT     = 0;
    localparam int STAT_AUTO_RUN_BIT   = 1;
    localparam int STAT_WAIT_END_BIT   = 2;
    localparam int STAT_PANEL_BIT      = 3;
    localparam int STAT_MODE_IN_BIT    = 4;

    // ------------------------------------------------------------
    // Run control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_ACTIVE,
        RUN_FINISH_MOVE,
        RUN_WAIT_END
    } mams_run_t;

endpackage : mams_pkg

//--- core/mams_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module mams_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } mams_sync_t;

    mams_sync_t state_q;
    mams_sync_t state_d;

    always_comb begin
        state_d = state_q;
        if (clkEn) begin
            state_d.meta   = asyncIn;
            state_d.stable = state_q.meta;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stable;
endmodule // mams_sync
`default_nettype wire

//--- verif/mams_host_model.sv
// Host controller model issuing single bus transfers
`timescale 1ns/1ps
`default_nettype none
module mams_host_model (
    input  wire logic        mclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [7:0]  haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end
    // Host sets or clears the request bit through these transfers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask
endmodule // mams_host_model
`default_nettype wire

//--- verif/mams_mode_select_asserts.sv
// Assertion checker for the mode selector
`timescale 1ns/1ps
`default_nettype none
module mams_mode_select_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic panelManual,
    input wire logic programEnd,
    input wire logic moveBusy,
    input wire logic manualOperation,
    input wire logic programRun,
    input wire logic subtaskRun,
    input wire logic newMoveAllowed
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence idleManual; !programRun && manualOperation ##1 manualOperation; endsequence
    sequence heldManual; manualOperation [*2]; endsequence
    AST_PANEL: assert property (panelManual [*4] |-> manualOperation) else $error("panel ignored");
    AST_PANEL_SUB: assert property (panelManual [*5] |-> !subtaskRun) else $error("subtask on");
    AST_END: assert property (programEnd |=> !programRun) else $error("no stop at end");
    AST_HOLD: assert property (programRun && manualOperation && moveBusy && !programEnd |=> programRun)
        else $error("run dropped");
    AST_START: assert property (idleManual |-> !programRun) else $error("started in manual");
    AST_SUB: assert property (heldManual |-> !subtaskRun) else $error("subtask in manual");
    AST_MOVE: assert property (heldManual |-> !newMoveAllowed) else $error("move in manual");
    AST_SUBRUN: assert property (subtaskRun |-> programRun) else $error("subtask alone");
endmodule // mams_mode_select_asserts
bind mams_mode_select mams_mode_select_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .panelManual(panelManual),
    .programEnd(programEnd), .moveBusy(moveBusy), .manualOperation(manualOperation), .programRun(programRun),
    .subtaskRun(subtaskRun), .newMoveAllowed(newMoveAllowed));
`default_nettype wire

//--- verif/tb_mams_mode_select.sv
// Self-checking testbench for the mode selector
`timescale 1ns/1ps
`default_nettype none
module tb_mams_mode_select;
    logic        mclk, rst_n, clkEn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rdData, seen;
    logic        panelManual, modeInputSingleAxis, modeInputTwoAxis, autoStart, moveBusy, programEnd;
    logic        manualOperation, programRun, subtaskRun, newMoveAllowed;
    logic [33:0] notes[$];
    logic [33:0] noteCur;
    int          fail_count, checks_done, i;
    integer      seed = 32'ha001;
    string       what[4] = '{"mode", "run", "read", "flags"};
    event        noteEv;
    assign hready = hreadyout;
    mams_mode_select dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .panelManual(panelManual),
        .modeInputSingleAxis(modeInputSingleAxis), .modeInputTwoAxis(modeInputTwoAxis),
        .autoStart(autoStart), .moveBusy(moveBusy), .programEnd(programEnd),
        .manualOperation(manualOperation), .programRun(programRun), .subtaskRun(subtaskRun),
        .newMoveAllowed(newMoveAllowed));
    mams_host_model host (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(noteEv) begin
        noteCur = notes.pop_front();
        case (noteCur[33:32])
            2'h0: seen = {31'h0, manualOperation};
            2'h1: seen = {31'h0, programRun};
            2'h2: seen = rdData;
            default: seen = {30'h0, subtaskRun, newMoveAllowed};
        endcase
        checks_done++;
        if (seen !== noteCur[31:0]) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what[noteCur[33:32]], noteCur[31:0], seen);
        end
    end
    task automatic note(input logic [1:0] k, input logic [31:0] v);
        #1;
        notes.push_back({k, v});
        -> noteEv;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, rdData);
        note(2'h2, e);
    endtask
    // Bits: panel, two-axis, host request, input enable, mode pin
    task automatic setMode(input logic [4:0] v);
        logic other;
        logic m;
        other = 1'($random(seed));
        m = v[4] | v[2] | (v[1] & v[0]);
        host.xfer(1'b1, mams_pkg::CTRL_OFFSET, {29'h0, v[3:1]}, rdData);
        panelManual <= v[4];
        modeInputTwoAxis <= v[3] ? v[0] : other;
        modeInputSingleAxis <= v[3] ? other : v[0];
        repeat (4) @(posedge mclk);
        note(2'h0, {31'h0, m});
        host.xfer(1'b0, mams_pkg::STATUS_OFFSET, 32'h0, rdData);
        rdData = rdData & 32'h1f;
        note(2'h2, {27'h0, v[0] | other, v[4], 2'h0, m});
    endtask
    task finish_test;
        $display("Checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        finish_test;
    end
    initial begin
        {rst_n, panelManual, modeInputSingleAxis, modeInputTwoAxis, autoStart, moveBusy, programEnd} = '0;
        clkEn = 1'b1;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        for (i = 0; i < 32; i++) setMode(i[4:0]);
        $display("mode table done");
        rd(mams_pkg::CTRL_OFFSET, 32'h7);
        host.xfer(1'b1, 8'h08, 32'h0, rdData);
        rd(8'h08, 32'h0);
        rd(mams_pkg::CTRL_OFFSET, 32'h7);
        $display("register test done");
        setMode(5'h00);
        autoStart <= 1'b1;
        moveBusy <= 1'b1;
        @(posedge mclk);
        autoStart <= 1'b0;
        repeat (2) @(posedge mclk);
        note(2'h1, 32'h1);
        note(2'h3, 32'h3);
        panelManual <= 1'b1;
        repeat (5) @(posedge mclk);
        note(2'h1, 32'h1);
        note(2'h3, 32'h0);
        moveBusy <= 1'b0;
        repeat (3) @(posedge mclk);
        note(2'h1, 32'h0);
        host.xfer(1'b0, mams_pkg::STATUS_OFFSET, 32'h0, rdData);
        rdData = rdData & 32'hf;
        note(2'h2, 32'hd);
        programEnd <= 1'b1;
        @(posedge mclk);
        programEnd <= 1'b0;
        autoStart <= 1'b1;
        repeat (3) @(posedge mclk);
        note(2'h1, 32'h0);
        autoStart <= 1'b0;
        $display("run test done");
        clkEn <= 1'b0;
        panelManual <= 1'b0;
        repeat (6) @(posedge mclk);
        note(2'h0, 32'h1);
        clkEn <= 1'b1;
        repeat (4) @(posedge mclk);
        note(2'h0, 32'h0);
        $display("clock enable test done");
        finish_test;
    end
endmodule // tb_mams_mode_select
`default_nettype wire
